// ==== core/sadc_ctrl.sv ====
`timescale 1ns/1ns
`include "sadc_map.svh"

module sadc_ctrl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic comp_in,
   output sadc_pkg::sadc_amux_s amux,
   input wire logic [4:0] pin_analog_sel,
   input wire logic [4:0] pin_pullup_req,
   output logic [4:0] pin_pullup_en,
   output logic [4:0] pin_shared_fn_en,
   output logic conv_done,
   output logic irq
);

   logic [7:0] ctrl_a_ff;
   logic [7:0] ctrl_b_ff;
   logic [7:0] irq_mask_ff;
   logic irq_status_ff;
   logic [7:0] rdata_ff;
   logic [11:0] result_ff;
   logic [11:0] sar_ff;
   logic [11:0] nxt_sar;
   logic busy_ff;
   logic done_ff;
   sadc_pkg::sadc_state_e state_ff;
   sadc_pkg::sadc_state_e nxt_state;
   logic [2:0] phase_ff;
   logic [2:0] nxt_phase;
   logic [3:0] bit_ff;
   logic [3:0] nxt_bit;
   logic [6:0] div_cnt_ff;
   logic [2:0] comp_sync_ff;
   logic comp_ff;
   logic wr_a;
   logic wr_b;
   logic launch;
   logic tick;
   logic finish;
   logic enable;
   logic [2:0] src;
   logic [3:0] chan;
   logic ext_path;
   logic [6:0] div_mask;
   logic [11:0] sar_kept;

   function automatic logic [11:0] bit_mask(input logic [3:0] idx);
      bit_mask = 12'h001 << idx;
   endfunction

   // Pack the 12-bit value into one result byte per the alignment bit
   function automatic logic [7:0] fmt_byte(input logic [11:0] d, input logic align,
                                           input logic high);
      if (high) begin
         fmt_byte = align ? {4'h0, d[11:8]} : d[11:4];
      end else begin
         fmt_byte = align ? d[7:0] : {d[3:0], 4'h0};
      end
   endfunction

   assign enable = ctrl_a_ff[`SADC_A_ENABLE];
   assign src = ctrl_b_ff[`SADC_B_SRC_HI:`SADC_B_SRC_LO];
   assign chan = ctrl_a_ff[`SADC_A_CHAN_HI:`SADC_A_CHAN_LO];
   assign wr_a = reg_wr && (reg_addr == `SADC_OFS_CTRL_A);
   assign wr_b = reg_wr && (reg_addr == `SADC_OFS_CTRL_B);

   // High-then-low on the start bit; a start while busy or with enable clear in the low write is dropped
   assign launch = wr_a && ctrl_a_ff[`SADC_A_START] && !reg_wdata[`SADC_A_START]
                   && reg_wdata[`SADC_A_ENABLE] && !busy_ff;

   // Control registers; the busy bit is never stored here
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_a_ff <= `SADC_RST_CTRL_A;
         ctrl_b_ff <= `SADC_RST_CTRL_B;
      end else begin
         if (wr_a) begin
            ctrl_a_ff <= reg_wdata & 8'hbf;
         end
         if (wr_b) begin
            ctrl_b_ff <= reg_wdata;
         end
      end
   end

   // Divider tick: period of 2^sel system clocks, restarted at each launch
   assign div_mask = 7'((8'h01 << ctrl_b_ff[`SADC_B_DIV_HI:`SADC_B_DIV_LO]) - 8'h01);
   assign tick = ((div_cnt_ff & div_mask) == div_mask);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_cnt_ff <= 7'h00;
      end else if (launch || state_ff == sadc_pkg::SADC_IDLE) begin
         div_cnt_ff <= 7'h00;
      end else begin
         div_cnt_ff <= div_cnt_ff + 7'h01;
      end
   end

   // Comparator comes from the analog core, asynchronous to clk
   always_ff @(posedge clk) begin
      if (!resetn) begin
         comp_sync_ff <= 3'h0;
         comp_ff <= 1'b0;
      end else begin
         comp_sync_ff <= {comp_sync_ff[1:0], comp_in};
         if (comp_sync_ff[1] == comp_sync_ff[2]) begin
            comp_ff <= comp_sync_ff[2];
         end
      end
   end

   // Bit step of six ticks leaves room for the comparator synchroniser at div 1
   assign sar_kept = comp_ff ? sar_ff : (sar_ff & ~bit_mask(bit_ff));
   assign finish = (state_ff == sadc_pkg::SADC_CONVERT) && tick
                   && (phase_ff == `SADC_BIT_TICKS - 3'h1) && (bit_ff == 4'h0);

   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_bit = bit_ff;
      nxt_sar = sar_ff;
      unique case (state_ff)
         sadc_pkg::SADC_IDLE: begin
            if (launch) begin
               nxt_state = sadc_pkg::SADC_SAMPLE;
               nxt_phase = 3'h0;
               nxt_sar = bit_mask(`SADC_RESULT_MSB);
            end
         end
         sadc_pkg::SADC_SAMPLE: begin
            if (tick) begin
               nxt_phase = phase_ff + 3'h1;
               if (phase_ff == `SADC_SAMPLE_TICKS - 3'h1) begin
                  nxt_state = sadc_pkg::SADC_CONVERT;
                  nxt_phase = 3'h0;
                  nxt_bit = `SADC_RESULT_MSB;
               end
            end
         end
         sadc_pkg::SADC_CONVERT: begin
            if (tick) begin
               nxt_phase = phase_ff + 3'h1;
               if (phase_ff == `SADC_BIT_TICKS - 3'h1) begin
                  nxt_phase = 3'h0;
                  nxt_sar = sar_kept;
                  if (bit_ff == 4'h0) begin
                     nxt_state = sadc_pkg::SADC_IDLE;
                  end else begin
                     nxt_bit = bit_ff - 4'h1;
                     nxt_sar = sar_kept | bit_mask(bit_ff - 4'h1);
                  end
               end
            end
         end
      endcase
      // The low write of the start sequence may itself switch the converter on
      if (!enable && !launch) begin
         nxt_state = sadc_pkg::SADC_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff <= sadc_pkg::SADC_IDLE;
         phase_ff <= 3'h0;
         bit_ff <= 4'h0;
         sar_ff <= 12'h000;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         bit_ff <= nxt_bit;
         sar_ff <= nxt_sar;
      end
   end

   // Busy sets at launch and clears as the result loads at finish; an abort by disable leaves the result alone
   always_ff @(posedge clk) begin
      if (!resetn) begin
         busy_ff <= 1'b0;
         result_ff <= `SADC_RST_RESULT;
         done_ff <= 1'b0;
      end else begin
         done_ff <= finish && enable;
         if (launch) begin
            busy_ff <= 1'b1;
         end else if (!enable) begin
            busy_ff <= 1'b0;
         end else if (finish) begin
            busy_ff <= 1'b0;
            result_ff <= sar_kept;
         end
      end
   end

   // Completion flag: write one clears, a new completion wins over the clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_status_ff <= 1'b0;
         irq_mask_ff <= `SADC_RST_IRQ_MASK;
      end else begin
         if (finish && enable) begin
            irq_status_ff <= 1'b1;
         end else if (reg_wr && reg_addr == `SADC_OFS_IRQ_STATUS
                      && reg_wdata[`SADC_IRQ_DONE]) begin
            irq_status_ff <= 1'b0;
         end
         if (reg_wr && reg_addr == `SADC_OFS_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata & 8'h01;
         end
      end
   end

   assign irq = irq_status_ff && irq_mask_ff[`SADC_IRQ_DONE];
   assign conv_done = done_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `SADC_OFS_RESULT_LOW: begin
               rdata_ff <= fmt_byte(result_ff, ctrl_a_ff[`SADC_A_ALIGN], 1'b0);
            end
            `SADC_OFS_RESULT_HIGH: begin
               rdata_ff <= fmt_byte(result_ff, ctrl_a_ff[`SADC_A_ALIGN], 1'b1);
            end
            `SADC_OFS_CTRL_A: begin
               rdata_ff <= ctrl_a_ff | {1'b0, busy_ff, 6'h00};
            end
            `SADC_OFS_CTRL_B: begin
               rdata_ff <= ctrl_b_ff;
            end
            `SADC_OFS_IRQ_STATUS: begin
               rdata_ff <= {7'h00, irq_status_ff};
            end
            `SADC_OFS_IRQ_MASK: begin
               rdata_ff <= irq_mask_ff;
            end
            default: begin
               rdata_ff <= 8'h00;
            end
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata = rdata_ff;

   // Input routing toward the analog core
   assign ext_path = (src == 3'h0) || (src >= 3'h5);

   always_comb begin
      amux.power_en = enable;
      amux.sample_en = enable && (state_ff == sadc_pkg::SADC_SAMPLE);
      amux.ext_sel = 5'h00;
      for (int i = 0; i < `SADC_EXT_CHANNELS; i++) begin
         amux.ext_sel[i] = enable && ext_path && (chan == 4'(i));
      end
      amux.bandgap_sel = enable && (src == 3'h1);
      amux.amp_out_sel = enable && (src == 3'h2);
      amux.amp_inp_sel = enable && (src == 3'h3);
      amux.ground_sel = enable && (src == 3'h4);
      amux.ref_supply_sel = (ctrl_b_ff[`SADC_B_REF_HI:`SADC_B_REF_LO] == 2'h1);
      amux.dac_code = sar_ff;
   end

   // Analog selection overrides the pin's shared function and its pull-high
   assign pin_shared_fn_en = ~pin_analog_sel;
   assign pin_pullup_en = pin_pullup_req & ~pin_analog_sel;

endmodule

// ==== core/sadc_map.svh ====
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// Register offsets on the byte-wide register port
`define SADC_OFS_RESULT_LOW 3'h0
`define SADC_OFS_RESULT_HIGH 3'h1
`define SADC_OFS_CTRL_A 3'h2
`define SADC_OFS_CTRL_B 3'h3
`define SADC_OFS_IRQ_STATUS 3'h4
`define SADC_OFS_IRQ_MASK 3'h5

// converter_control_a fields
`define SADC_A_START 7
`define SADC_A_BUSY 6
`define SADC_A_ENABLE 5
`define SADC_A_ALIGN 4
`define SADC_A_CHAN_HI 3
`define SADC_A_CHAN_LO 0

// converter_control_b fields
`define SADC_B_SRC_HI 7
`define SADC_B_SRC_LO 5
`define SADC_B_REF_HI 4
`define SADC_B_REF_LO 3
`define SADC_B_DIV_HI 2
`define SADC_B_DIV_LO 0

// Interrupt status / mask layout
`define SADC_IRQ_DONE 0

// Reset values
`define SADC_RST_CTRL_A 8'h00
`define SADC_RST_CTRL_B 8'h00
`define SADC_RST_IRQ_MASK 8'h00
`define SADC_RST_RESULT 12'h000

// Sequencing in conversion clock ticks, result MSB index and external channel count
`define SADC_SAMPLE_TICKS 3'h4
`define SADC_BIT_TICKS 3'h6
`define SADC_RESULT_MSB 4'hb
`define SADC_EXT_CHANNELS 5

`endif

// ==== core/sadc_pkg.sv ====
package sadc_pkg;

   typedef enum logic [1:0] {
      SADC_IDLE,
      SADC_SAMPLE,
      SADC_CONVERT
   } sadc_state_e;

   // Controls toward the analog front end
   typedef struct packed {
      logic power_en;
      logic sample_en;
      logic [4:0] ext_sel;
      logic bandgap_sel;
      logic amp_out_sel;
      logic amp_inp_sel;
      logic ground_sel;
      logic ref_supply_sel;
      logic [11:0] dac_code;
   } sadc_amux_s;

endpackage

// ==== tb/sadc_afe_model.sv ====
`timescale 1ns/1ns
module sadc_afe_model #(
   parameter logic [11:0] LVL [8] = '{default: 12'h0000}
) (
   input logic clk,
   input sadc_pkg::sadc_amux_s amux,
   output logic comp_in
);
   logic [11:0] lvl;
   logic live;
   logic wobble_ff = 1'h0;
   // A floating or unpowered input gives the comparator no stable answer
   always_ff @(posedge clk) begin
      wobble_ff <= ~wobble_ff;
   end
   always_comb begin
      lvl = 12'h0000;
      for (int i = 0; i < 5; i++) begin
         if (amux.ext_sel[i]) begin
            lvl = LVL[i];
         end
      end
      if (amux.bandgap_sel | amux.amp_out_sel | amux.amp_inp_sel) begin
         lvl = amux.bandgap_sel ? LVL[5] : (amux.amp_out_sel ? LVL[6] : LVL[7]);
      end
   end
   assign live = amux.power_en && (amux.ext_sel != 5'h00 || amux.bandgap_sel ||
      amux.amp_out_sel || amux.amp_inp_sel || amux.ground_sel);
   assign comp_in = live ? (lvl >= amux.dac_code) : wobble_ff;
endmodule

// ==== tb/sadc_ctrl_sva.sv ====
`timescale 1ns/1ns
module sadc_ctrl_sva (
   input logic clk,
   input logic resetn,
   input logic [2:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic comp_in,
   input sadc_pkg::sadc_amux_s amux,
   input logic [4:0] pin_analog_sel,
   input logic [4:0] pin_pullup_req,
   input logic [4:0] pin_pullup_en,
   input logic [4:0] pin_shared_fn_en,
   input logic conv_done,
   input logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_pullup_cut: assert property (pin_pullup_en == (pin_pullup_req & ~pin_analog_sel))
      else $error("pull-high left on analog pin");
   a_shared_fn_off: assert property (pin_shared_fn_en == ~pin_analog_sel)
      else $error("shared function left on analog pin");
   a_done_pulse: assert property (conv_done |=> !conv_done)
      else $error("done longer than one cycle");
   a_ext_onehot: assert property ($onehot0(amux.ext_sel))
      else $error("several external channels routed");
   a_off_quiet: assert property (!amux.power_en |-> amux.ext_sel == 5'h00 && !amux.sample_en)
      else $error("front end active while off");
   a_src_exclusive: assert property ($onehot0({amux.ext_sel != 5'h00, amux.bandgap_sel,
      amux.amp_out_sel, amux.amp_inp_sel, amux.ground_sel}))
      else $error("several sources routed");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_done_powered: assert property (conv_done |-> $past(amux.power_en))
      else $error("done while converter off");
   a_sample_code: assert property ($rose(amux.sample_en) |-> amux.dac_code == 12'h0800)
      else $error("trial code not at midscale");
endmodule

bind sadc_ctrl sadc_ctrl_sva sadc_ctrl_sva_i (
   .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
   .amux(amux), .pin_analog_sel(pin_analog_sel), .pin_pullup_req(pin_pullup_req),
   .pin_pullup_en(pin_pullup_en), .pin_shared_fn_en(pin_shared_fn_en),
   .conv_done(conv_done), .irq(irq)
);

// ==== tb/sadc_ctrl_tb.sv ====
`timescale 1ns/1ns
module sadc_ctrl_tb;
   typedef struct packed {
      logic [7:0] b;
      logic [7:0] a;
      logic [11:0] v;
   } sadc_row_s;
   localparam logic [11:0] LVL [8] = '{12'h05a3, 12'h0fff, 12'h0123, 12'h0000, 12'h08ff,
      12'h04d2, 12'h0ace, 12'h0001};
   // Internal sources park the channel field at 5..15; the regulator switch sits outside
   // this block and is taken as open on the supply-reference rows
   sadc_row_s rows [8] = '{'{8'h00, 8'h20, LVL[0]}, '{8'h29, 8'h35, LVL[5]},
      '{8'h52, 8'h29, LVL[6]}, '{8'h7b, 8'h3f, LVL[7]}, '{8'h84, 8'h2c, 12'h0000},
      '{8'had, 8'h31, LVL[1]}, '{8'hd6, 8'h23, LVL[3]}, '{8'hff, 8'h34, LVL[4]}};
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [4:0] pin_analog_sel = 5'h00;
   logic [4:0] pin_pullup_req = 5'h00;
   logic [7:0] reg_rdata;
   logic comp_in;
   logic conv_done;
   logic irq;
   logic [4:0] pin_pullup_en;
   logic [4:0] pin_shared_fn_en;
   sadc_pkg::sadc_amux_s amux;
   sadc_row_s r;
   int fail_count = 0;
   int num_checks = 0;
   int n;
   sadc_ctrl sadc_ctrl_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .comp_in(comp_in), .amux(amux), .pin_analog_sel(pin_analog_sel),
      .pin_pullup_req(pin_pullup_req), .pin_pullup_en(pin_pullup_en),
      .pin_shared_fn_en(pin_shared_fn_en), .conv_done(conv_done), .irq(irq));
   sadc_afe_model #(.LVL(LVL)) sadc_afe_model_i (.clk(clk), .amux(amux), .comp_in(comp_in));
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      chk8(reg_rdata, exp);
   endtask
   task automatic run(input logic [7:0] a);
      wr(3'h2, a | 8'h80);
      wr(3'h2, a);
      n = 0;
      while (conv_done !== 1'h1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic complete_run;
      $display("Checks %0d, errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'h1;
      for (int i = 1; i < 8; i++) begin
         rd(3'(i), 8'h00);
      end
      wr(3'h5, 8'h01);
      for (int i = 0; i < 8; i++) begin
         r = rows[i];
         pin_analog_sel <= 5'(i);
         pin_pullup_req <= 5'h1f;
         wr(3'h3, r.b);
         run(r.a);
         chk1(n == (76 << i) + 1, 1'h1);
         chk8({3'h0, pin_pullup_en}, {3'h0, ~5'(i)});
         chk8({3'h0, pin_shared_fn_en}, {3'h0, ~5'(i)});
         chk1(irq, 1'h1);
         chk1(amux.ref_supply_sel, r.b[4:3] == 2'h1);
         chk8({3'h0, amux.ext_sel}, (r.b[7:5] inside {3'h0, [3'h5:3'h7]} && r.a[3:0] < 5) ?
            8'h01 << r.a[3:0] : 8'h00);
         chk8({4'h0, amux.bandgap_sel, amux.amp_out_sel, amux.amp_inp_sel, amux.ground_sel},
            (r.b[7:5] inside {[3'h1:3'h4]}) ? 8'h10 >> r.b[7:5] : 8'h00);
         if (r.a[4]) begin
            rd(3'h1, {4'h0, r.v[11:8]});
            rd(3'h0, r.v[7:0]);
         end else begin
            rd(3'h1, r.v[11:4]);
            rd(3'h0, {r.v[3:0], 4'h0});
         end
         rd(3'h2, r.a);
         wr(3'h4, 8'h01);
         @(negedge clk);
         chk1(irq, 1'h0);
      end
      wr(3'h2, 8'h24);
      rd(3'h1, 8'h8f);
      rd(3'h0, 8'hf0);
      wr(3'h1, 8'h55);
      wr(3'h2, 8'h44);
      rd(3'h2, 8'h04);
      rd(3'h1, 8'h8f);
      // Divide by 8 keeps the conversion clock inside the recommended period window
      wr(3'h3, 8'h03);
      // Enable arrives only with the low half of the start sequence
      wr(3'h2, 8'h82);
      wr(3'h2, 8'h22);
      rd(3'h2, 8'h62);
      repeat (20) @(posedge clk);
      // Dropping enable mid-conversion must abort without a result
      wr(3'h2, 8'h02);
      repeat (200) @(posedge clk);
      rd(3'h4, 8'h00);
      rd(3'h2, 8'h02);
      rd(3'h1, 8'h8f);
      wr(3'h2, 8'h22);
      rd(3'h2, 8'h22);
      wr(3'h2, 8'ha2);
      wr(3'h2, 8'h02);
      rd(3'h2, 8'h02);
      wr(3'h5, 8'h00);
      wr(3'h2, 8'ha2);
      wr(3'h2, 8'h22);
      run(8'h22);
      chk1(n == 605, 1'h1);
      chk1(irq, 1'h0);
      rd(3'h4, 8'h01);
      rd(3'h1, 8'h12);
      rd(3'h0, 8'h30);
      // Reset in mid-conversion must clear the result and every register
      wr(3'h2, 8'ha2);
      wr(3'h2, 8'h22);
      repeat (10) @(posedge clk);
      resetn <= 1'h0;
      repeat (3) @(posedge clk);
      resetn <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         rd(3'(i), 8'h00);
      end
      chk1(irq, 1'h0);
      complete_run;
   end
endmodule
